// ==== hdl/rcpt_pkg.sv ====
package rcpt_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_FLAGS_OFF  = 8'h00;
  localparam logic [7:0] REG_STATUS_OFF = 8'h04;
  localparam logic [7:0] REG_PC_OFF     = 8'h08;
  localparam logic [7:0] REG_CTRL_OFF   = 8'h0c;
  // ---------------------------------------------------------------
  // Flag field positions
  // ---------------------------------------------------------------
  localparam int FLG_BROWN = 0;
  localparam int FLG_POR   = 1;
  localparam int FLG_DOWN  = 2;
  localparam int FLG_TMO   = 3;
  localparam int FLG_INSTR = 4;
  localparam int FLG_CFG   = 5;
  localparam int FLG_UNDER = 6;
  localparam int FLG_OVER  = 7;
  localparam int FLG_W     = 8;
  localparam logic [7:0] FLAGS_RESET = 8'h3c;
  // ---------------------------------------------------------------
  // Status and control field positions
  // ---------------------------------------------------------------
  localparam int ST_INT_RESET = 0;
  localparam int ST_DELAY     = 1;
  localparam int ST_MISMATCH  = 2;
  localparam int ST_COUNT_LSB = 16;
  localparam int CTRL_RESET_INSTR = 0;
  // ---------------------------------------------------------------
  // Power modes and vectors
  // ---------------------------------------------------------------
  localparam logic [1:0] PM_FULL  = 2'h0;
  localparam logic [1:0] PM_RUN   = 2'h1;
  localparam logic [1:0] PM_IDLE  = 2'h2;
  localparam logic [1:0] PM_SLEEP = 2'h3;
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] PC_RESET    = 21'h000000;
  localparam logic [PC_W-1:0] VEC_HIGH    = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW     = 21'h000018;
  localparam logic [PC_W-1:0] PC_WAKE_INC = 21'h000002;
  // ---------------------------------------------------------------
  // Power-up delay
  // ---------------------------------------------------------------
  localparam int DLY_W = 11;
  localparam logic [DLY_W-1:0] DLY_LAST = 11'h7ff;
endpackage : rcpt_pkg

// ==== hdl/rcpt_reset_cause.sv ====
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1 - Brown-out flag cleared by brown-out reset or power-on reset.
// R2 - Software reads flag pair brown-out 0, power-on 1 as brown-out.
// R3 - Regulator disabled blocks brown-out reset; power-on still clears brown-out flag.
// R4 - Config words constantly compared with complement shadows; mismatch resets.
// R5 - Only a mismatch event clears the mismatch flag.
// R6 - Every hard or power reset reloads configuration words on restart.
// R7 - Power-up delay is always on: 11-bit, 2048 RC oscillator periods.
// R8 - Internal reset held while the power-up delay counts.
// R9 - Power-up delay starts only after power-on pulse is released.
// R10 - Pin held low past delay expiry: release runs immediately.
// R11 - Undefined registers unknown after power-on, kept across other resets.
// R12 - Watchdog wake resumes operation, leaving most state unchanged.
// R13 - Power-on: PC 0, set mismatch, instr, timeout, powerdown; clear other flags.
// R14 - Brown-out: PC 0, set mismatch, instr, timeout, powerdown; clear brown-out.
// R15 - Reset instruction: PC 0, clear only reset-instruction flag.
// R16 - Pin reset: PC 0; timeout set in managed modes; powerdown cleared idle/sleep.
// R17 - Stack faults set their flags; underflow without reset when disabled. Code sets overflow flag only when reset enabled.
// R18 - Watchdog timeout in run modes: reset, PC 0, clear timeout only.
// R19 - Watchdog timeout idle/sleep: wake, clear timeout and powerdown, PC plus 2.
// R20 - Interrupt exit from managed mode clears PD, continues at PC plus 2.
// R21 - Interrupt wake with global enable set loads vector 0008h or 0018h.
// R22 - After brown-out full delay runs; restarts on new brown-out.
// R23 - Power-on flag never set by hardware, only software.
// R24 - Brown-out reset held while supply below threshold.
// R25 - Internal reset while any source or delay active; released synchronously.
module rcpt_reset_cause
  import rcpt_pkg::*;
#(
  parameter int CFG_W = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic             internal_rc_oscillator,
  input  wire logic             external_reset_pin,
  input  wire logic             poweron_detect,
  input  wire logic             brownout_detect,
  input  wire logic             regulator_enable,
  input  wire logic [CFG_W-1:0] config_word,
  input  wire logic [CFG_W-1:0] config_shadow,
  input  wire logic             watchdog_timeout,
  input  wire logic             reset_instr,
  input  wire logic             stack_overflow,
  input  wire logic             stack_underflow,
  input  wire logic             stack_fault_reset_enable,
  input  wire logic [1:0]       power_mode,
  input  wire logic             interrupt_wake,
  input  wire logic             interrupt_high_priority,
  input  wire logic             high_priority_global_int_enable,
  input  wire logic             low_priority_global_int_enable,
  input  wire logic [PC_W-1:0]  pc_current,
  output logic                  internal_reset_n,
  output logic                  config_reload,
  output logic                  pc_load_valid,
  output logic      [PC_W-1:0]  pc_load_value,
  output logic      [FLG_W-1:0] reset_control_register
);

  function automatic logic [PC_W-1:0] pc_plus2(input logic [PC_W-1:0] pc);
    pc_plus2 = pc + PC_WAKE_INC;
  endfunction : pc_plus2

  // ---------------------------------------------------------------
  // Input synchronisers (RC oscillator, pin, power-on, brown-out), three stages, change on agreement
  // ---------------------------------------------------------------
  logic [2:0] rc_sync_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] por_sync_reg;
  logic [2:0] brn_sync_reg;
  logic       rc_level_reg;
  logic       pin_level_reg;
  logic       por_level_reg;
  logic       brn_level_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_sync_reg  <= 3'h0;
      pin_sync_reg <= 3'h7;
      por_sync_reg <= 3'h7;
      brn_sync_reg <= 3'h0;
    end else begin
      rc_sync_reg  <= {rc_sync_reg[1:0], internal_rc_oscillator};
      pin_sync_reg <= {pin_sync_reg[1:0], external_reset_pin};
      por_sync_reg <= {por_sync_reg[1:0], poweron_detect};
      brn_sync_reg <= {brn_sync_reg[1:0], brownout_detect};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_level_reg  <= 1'b0;
      pin_level_reg <= 1'b1;
      por_level_reg <= 1'b1;
      brn_level_reg <= 1'b0;
    end else begin
      if (rc_sync_reg[1] == rc_sync_reg[2]) rc_level_reg <= rc_sync_reg[2];
      if (pin_sync_reg[1] == pin_sync_reg[2]) pin_level_reg <= pin_sync_reg[2];
      if (por_sync_reg[1] == por_sync_reg[2]) por_level_reg <= por_sync_reg[2];
      if (brn_sync_reg[1] == brn_sync_reg[2]) brn_level_reg <= brn_sync_reg[2];
    end
  end

  wire rc_tick     = (rc_sync_reg[1] == rc_sync_reg[2]) & rc_sync_reg[2] & ~rc_level_reg;
  wire pin_fall    = (pin_sync_reg[1] == pin_sync_reg[2]) & ~pin_sync_reg[2] & pin_level_reg;
  wire pin_low     = ~pin_level_reg;
  wire por_active  = por_level_reg;
  wire brn_active  = brn_level_reg & regulator_enable;  // R3 R24
  wire cfg_mismatch = ((config_word ^ config_shadow) != {CFG_W{1'b1}});  // R4

  // ---------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------
  logic       sw_reset_instr_reg;
  logic [FLG_W-1:0] flags_reg;
  logic [FLG_W-1:0] flags_next;
  logic             bus_flag_wr;

  wire run_mode     = (power_mode == PM_FULL) | (power_mode == PM_RUN);
  wire managed_mode = (power_mode != PM_FULL);
  wire idle_sleep   = (power_mode == PM_IDLE) | (power_mode == PM_SLEEP);
  wire ev_instr     = reset_instr | sw_reset_instr_reg;
  wire ev_dog_rst   = watchdog_timeout & run_mode;
  wire ev_dog_wake  = watchdog_timeout & idle_sleep;  // R12
  wire ev_int_wake  = interrupt_wake & managed_mode & ~ev_dog_wake;
  wire ev_stk_ovf   = stack_overflow & stack_fault_reset_enable;
  wire ev_stk_unf   = stack_underflow;
  wire stk_unf_rst  = stack_underflow & stack_fault_reset_enable;
  wire hard_event   = pin_fall | ev_instr | ev_dog_rst | ev_stk_ovf | stk_unf_rst | cfg_mismatch;
  wire gie_any      = high_priority_global_int_enable | low_priority_global_int_enable;

  // ---------------------------------------------------------------
  // Power-up delay counter
  // ---------------------------------------------------------------
  logic             delay_active_reg;
  logic [DLY_W-1:0] delay_count_reg;
  logic             delay_active_next;
  logic [DLY_W-1:0] delay_count_next;

  wire delay_hold = por_active | brn_active;
  wire delay_done = delay_active_reg & ~delay_hold & rc_tick & (delay_count_reg == DLY_LAST);

  always_comb begin
    delay_active_next = delay_active_reg;
    delay_count_next  = delay_count_reg;
    if (delay_hold) begin
      delay_active_next = 1'b1;  // R22
      delay_count_next  = '0;  // R9
    end else if (delay_done) begin
      delay_active_next = 1'b0;  // R7
      delay_count_next  = '0;
    end else if (delay_active_reg && rc_tick) begin
      delay_count_next  = delay_count_reg + 11'h001;  // R7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_active_reg <= 1'b1;
      delay_count_reg  <= '0;
    end else begin
      delay_active_reg <= delay_active_next;
      delay_count_reg  <= delay_count_next;
    end
  end

  // ---------------------------------------------------------------
  // Internal reset and configuration reload
  // ---------------------------------------------------------------
  wire reset_cond = delay_hold | delay_active_reg | pin_low | hard_event;  // R8 R10 R25

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_reset_n <= 1'b0;
      config_reload    <= 1'b0;
    end else begin
      internal_reset_n <= ~reset_cond;  // R25
      config_reload    <= ~internal_reset_n & ~reset_cond;  // R6
    end
  end

  // ---------------------------------------------------------------
  // Reset-cause and stack flags
  // ---------------------------------------------------------------
  logic [FLG_W-1:0] bus_wdata_flags;

  always_comb begin
    flags_next = flags_reg;  // R11
    if (bus_flag_wr) flags_next = bus_wdata_flags;
    if (ev_stk_ovf) flags_next[FLG_OVER] = 1'b1;  // R17
    if (ev_stk_unf) flags_next[FLG_UNDER] = 1'b1;  // R17
    if (ev_instr) flags_next[FLG_INSTR] = 1'b0;  // R15
    if (ev_dog_rst) flags_next[FLG_TMO] = 1'b0;  // R18
    if (ev_dog_wake) begin
      flags_next[FLG_TMO]  = 1'b0;  // R19
      flags_next[FLG_DOWN] = 1'b0;  // R19
    end
    if (ev_int_wake) flags_next[FLG_DOWN] = 1'b0;  // R20
    if (pin_fall && managed_mode) flags_next[FLG_TMO] = 1'b1;  // R16
    if (pin_fall && idle_sleep) flags_next[FLG_DOWN] = 1'b0;  // R16
    if (cfg_mismatch) flags_next[FLG_CFG] = 1'b0;  // R5
    if (brn_active || por_active) begin
      flags_next[FLG_CFG]   = 1'b1;  // R14
      flags_next[FLG_INSTR] = 1'b1;
      flags_next[FLG_TMO]   = 1'b1;
      flags_next[FLG_DOWN]  = 1'b1;
      flags_next[FLG_BROWN] = 1'b0;  // R1
    end
    if (por_active) begin
      flags_next[FLG_POR]   = 1'b0;  // R13 R23
      flags_next[FLG_OVER]  = 1'b0;
      flags_next[FLG_UNDER] = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= FLAGS_RESET;  // R13
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_control_register <= FLAGS_RESET;
    end else begin
      reset_control_register <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // Program counter load
  // ---------------------------------------------------------------
  wire [PC_W-1:0] int_target = !gie_any ? pc_plus2(pc_current) :
                               interrupt_high_priority ? VEC_HIGH : VEC_LOW;  // R21
  wire            pc_load_now = reset_cond | ev_dog_wake | ev_int_wake;
  wire [PC_W-1:0] pc_target  = reset_cond ? PC_RESET :  // R13 R14 R15 R16 R18
                               ev_dog_wake ? pc_plus2(pc_current) : int_target;  // R19 R20

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_load_valid <= 1'b0;
      pc_load_value <= PC_RESET;
    end else begin
      pc_load_valid <= pc_load_now;
      if (pc_load_now) pc_load_value <= pc_target;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;

  wire        addr_phase = hsel & htrans[1] & hready;
  wire        rd_req     = addr_phase & ~hwrite;
  wire        rd_stall   = rd_req & wr_pend_reg & hreadyout;
  wire [7:0]  req_off    = {haddr[7:2], 2'b00};
  wire        hi_zero    = (haddr[31:8] == 24'h000000);
  assign bus_flag_wr     = wr_pend_reg & (wr_addr_reg == REG_FLAGS_OFF);
  assign bus_wdata_flags = hwdata[FLG_W-1:0];
  wire        ctrl_wr    = wr_pend_reg & (wr_addr_reg == REG_CTRL_OFF);
  wire [31:0] status_word = {5'h00, delay_count_reg, 13'h0000, cfg_mismatch,
                             delay_active_reg, ~internal_reset_n};
  wire [31:0] rd_word = !hi_zero ? 32'h00000000 :
                        (req_off == REG_FLAGS_OFF)  ? {24'h000000, flags_reg} :
                        (req_off == REG_STATUS_OFF) ? status_word :
                        (req_off == REG_PC_OFF)     ? {11'h000, pc_load_value} :
                        32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hreadyout) begin
      wr_pend_reg <= addr_phase & hwrite & hi_zero & ~rd_stall;
      wr_addr_reg <= req_off;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= ~rd_stall;
      hresp     <= 1'b0;
      if (rd_req && !rd_stall) hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_reset_instr_reg <= 1'b0;
    end else begin
      sw_reset_instr_reg <= ctrl_wr & hwdata[CTRL_RESET_INSTR];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  delay_holds_reset_a: assert property (delay_active_reg |=> !internal_reset_n)  // R8
    else $error("reset released while delay counting");
  delay_full_span_a: assert property ($fell(delay_active_reg) |->  // R7
                                      $past(delay_count_reg) == DLY_LAST)
    else $error("delay ended early");
  delay_waits_por_a: assert property (por_active |=> delay_count_reg == '0)  // R9
    else $error("delay counted during power-on pulse");
  brn_restart_a: assert property (brn_active |=> delay_active_reg && delay_count_reg == '0)  // R22
    else $error("brown-out did not restart delay");
  brn_flag_clear_a: assert property ((brn_active || por_active) |=> !flags_reg[FLG_BROWN])  // R1
    else $error("brown-out flag not cleared");
  por_never_set_a: assert property (!flags_reg[FLG_POR] && !bus_flag_wr
                                    |=> !flags_reg[FLG_POR])  // R23
    else $error("hardware set power-on flag");
  cfg_flag_only_a: assert property ($fell(flags_reg[FLG_CFG]) |-> $past(cfg_mismatch))  // R5
    else $error("mismatch flag cleared without mismatch");
  mismatch_reset_a: assert property (cfg_mismatch |=> !internal_reset_n)  // R4
    else $error("mismatch did not reset");
  release_reload_a: assert property ($rose(internal_reset_n) |-> config_reload)  // R6
    else $error("no configuration reload on restart");
  dog_wake_pc_a: assert property (ev_dog_wake && !reset_cond |=>  // R19
                                  pc_load_valid && !flags_reg[FLG_DOWN])
    else $error("watchdog wake mishandled");
  instr_flag_a: assert property (ev_instr && !por_active && !brn_active |=>  // R15
                                 !flags_reg[FLG_INSTR] && pc_load_value == PC_RESET)
    else $error("reset instruction mishandled");

  delay_expiry_c: cover property (delay_done ##1 internal_reset_n);
  pin_reset_c: cover property (pin_fall ##1 !internal_reset_n);
  int_vector_c: cover property (ev_int_wake && gie_any && !reset_cond);
  bus_read_c: cover property (rd_req ##1 hreadyout);

endmodule : rcpt_reset_cause
`default_nettype wire

// ==== verification/rcpt_supply_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Supply monitors, RC oscillator and reset pin
// ---------------------------------------------------------------
module rcpt_supply_model (
  input  wire logic hclk,
  input  wire logic supply_up,
  input  wire logic supply_sag,
  input  wire logic pin_press,
  output logic      internal_rc_oscillator,
  output logic      poweron_detect,
  output logic      brownout_detect,
  output logic      external_reset_pin
);
  int unsigned por_cnt = 0;
  // Free running, four system clocks a period
  initial begin
    internal_rc_oscillator = 1'b0;
    #3;
    forever #8 internal_rc_oscillator = ~internal_rc_oscillator;
  end
  // Power-on pulse ends 40 cycles after supply is up
  always @(posedge hclk) begin
    if (!supply_up) begin
      por_cnt <= 0;
    end else if (por_cnt < 40) begin
      por_cnt <= por_cnt + 1;
    end
  end
  assign poweron_detect     = !supply_up || (por_cnt < 40);
  assign brownout_detect    = supply_sag;
  assign external_reset_pin = ~pin_press;
endmodule : rcpt_supply_model
`default_nettype wire

// ==== verification/rcpt_reset_cause_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcpt_reset_cause_tb
  import rcpt_pkg::*;
;
  typedef struct packed {
    logic [2:0] kind; logic [1:0] mode; logic en; logic [1:0] gie; logic hp;
    logic [7:0] pre; logic [7:0] exp; logic rst; logic [PC_W-1:0] pc;
  } rcpt_case_t;
  logic              hclk, hresetn, hsel, hwrite, regulator_enable, gie_h, gie_l;
  logic [31:0]       haddr, hwdata, rv, rcap;
  logic [1:0]        htrans, power_mode;
  logic [2:0]        hsize;
  logic [15:0]       config_word, config_shadow;
  logic              watchdog_timeout, reset_instr, stack_overflow, stack_underflow;
  logic              stack_fault_reset_enable, interrupt_wake, interrupt_high_priority;
  logic [PC_W-1:0]   pc_current;
  logic              supply_up, supply_sag, pin_press, rdy, saw_rst, saw_pcl;
  wire logic [31:0]  hrdata;
  wire logic         hreadyout, hresp, rc, por, brn, pin, internal_reset_n;
  wire logic         config_reload, pc_load_valid;
  wire logic [PC_W-1:0] pc_load_value;
  wire logic [FLG_W-1:0] flags;
  int                mismatches = 0;
  int                n_checks = 0;
  rcpt_case_t        tbl [16];
  rcpt_case_t        c;
  // ---------------------------------------------------------------
  // Design and far side
  // ---------------------------------------------------------------
  rcpt_reset_cause u_rcpt_reset_cause (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_rc_oscillator(rc), .external_reset_pin(pin), .poweron_detect(por),
    .brownout_detect(brn), .regulator_enable(regulator_enable), .config_word(config_word),
    .config_shadow(config_shadow), .watchdog_timeout(watchdog_timeout),
    .reset_instr(reset_instr), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow), .stack_fault_reset_enable(stack_fault_reset_enable),
    .power_mode(power_mode), .interrupt_wake(interrupt_wake),
    .interrupt_high_priority(interrupt_high_priority),
    .high_priority_global_int_enable(gie_h), .low_priority_global_int_enable(gie_l),
    .pc_current(pc_current), .internal_reset_n(internal_reset_n),
    .config_reload(config_reload), .pc_load_valid(pc_load_valid),
    .pc_load_value(pc_load_value), .reset_control_register(flags));
  rcpt_supply_model u_rcpt_supply_model (.hclk(hclk), .supply_up(supply_up),
    .supply_sag(supply_sag), .pin_press(pin_press), .internal_rc_oscillator(rc),
    .poweron_detect(por), .brownout_detect(brn), .external_reset_pin(pin));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(negedge hclk) if (internal_reset_n !== 1'b1) saw_rst = 1'b1;
  always @(negedge hclk) if (pc_load_valid === 1'b1) saw_pcl = 1'b1;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rcap = hrdata;
      k++;
      @(posedge hclk);
    end while (rdy !== 1'b1 && k < 50);
    chk("hreadyout", 1, rdy);
    if (rdy !== 1'b1) end_of_test();
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = rcap;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rv);
    chk("hresp", 0, hresp);
  endtask : rd
  task automatic wait_rel(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (internal_reset_n !== 1'b1 && n <= hi);
    chk("release in time", 1, internal_reset_n === 1'b1);
    chk("release not early", 1, n >= lo);
    if (internal_reset_n !== 1'b1) end_of_test();
  endtask : wait_rel
  task automatic ev(input logic [2:0] k);
    @(posedge hclk);
    case (k)
      3'h0: reset_instr <= 1'b1;
      3'h1: watchdog_timeout <= 1'b1;
      3'h2: pin_press <= 1'b1;
      3'h3: stack_overflow <= 1'b1;
      3'h4: stack_underflow <= 1'b1;
      default: interrupt_wake <= 1'b1;
    endcase
    repeat (k == 3'h2 ? 10 : 1) @(posedge hclk);
    {reset_instr, watchdog_timeout, pin_press, stack_overflow} <= 4'h0;
    {stack_underflow, interrupt_wake} <= 2'h0;
  endtask : ev
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, gie_h, gie_l, interrupt_high_priority} = '0;
    {watchdog_timeout, reset_instr, stack_overflow, stack_underflow, interrupt_wake} = '0;
    {stack_fault_reset_enable, supply_up, supply_sag, pin_press, saw_rst, saw_pcl} = '0;
    {haddr, hwdata, htrans, power_mode} = '0;
    hsize = 3'h2;
    regulator_enable = 1'b1;
    config_word = 16'h5aa5;
    config_shadow = 16'ha55a;
    pc_current = 21'h000100;
    tbl[0]  = '{0, PM_FULL,  0, 0, 0, 8'h3f, 8'h2f, 1, 21'h0};
    tbl[1]  = '{1, PM_IDLE,  0, 0, 0, 8'h3f, 8'h33, 0, 21'h102};
    tbl[2]  = '{1, PM_FULL,  0, 0, 0, 8'h3f, 8'h37, 1, 21'h0};
    tbl[3]  = '{1, PM_SLEEP, 0, 0, 0, 8'h3f, 8'h33, 0, 21'h102};
    tbl[4]  = '{1, PM_RUN,   0, 0, 0, 8'h3f, 8'h37, 1, 21'h0};
    tbl[5]  = '{2, PM_FULL,  0, 0, 0, 8'h37, 8'h37, 1, 21'h0};
    tbl[6]  = '{2, PM_RUN,   0, 0, 0, 8'h37, 8'h3f, 1, 21'h0};
    tbl[7]  = '{2, PM_IDLE,  0, 0, 0, 8'h37, 8'h3b, 1, 21'h0};
    tbl[8]  = '{2, PM_SLEEP, 0, 0, 0, 8'h37, 8'h3b, 1, 21'h0};
    tbl[9]  = '{3, PM_FULL,  1, 0, 0, 8'h3f, 8'hbf, 1, 21'h0};
    tbl[10] = '{4, PM_FULL,  1, 0, 0, 8'h3f, 8'h7f, 1, 21'h0};
    tbl[11] = '{5, PM_SLEEP, 0, 2, 1, 8'h3f, 8'h3b, 0, 21'h008};
    tbl[12] = '{5, PM_IDLE,  0, 1, 0, 8'h3f, 8'h3b, 0, 21'h018};
    tbl[13] = '{5, PM_RUN,   0, 0, 0, 8'h3f, 8'h3b, 0, 21'h102};
    tbl[14] = '{4, PM_FULL,  0, 0, 0, 8'h3f, 8'h7f, 0, '1};
    tbl[15] = '{3, PM_FULL,  0, 0, 0, 8'h3f, 8'h3f, 0, '1};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, REG_STATUS_OFF, 32'h0);
    chk("status reset bit", 1, rv[0]);
    supply_up <= 1'b1;
    wait_rel(40 + 2047 * 4, 40 + 2048 * 4 + 80);
    chk("config_reload", 1, config_reload);
    rd(REG_FLAGS_OFF, 32'h3c, "flags power-on");
    rd(REG_PC_OFF, 32'h0, "pc power-on");
    ahb(1'b1, REG_FLAGS_OFF, 32'h3f);
    rd(REG_FLAGS_OFF, 32'h3f, "flags written");
    ahb(1'b1, REG_CTRL_OFF, 32'h1);
    repeat (4) @(posedge hclk);
    wait_rel(0, 40);
    rd(REG_FLAGS_OFF, 32'h2f, "flags reset instr");
    rd(REG_CTRL_OFF, 32'h0, "ctrl read");
    rd(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) begin
      c = tbl[i];
      ahb(1'b1, REG_FLAGS_OFF, {24'h0, c.pre});
      power_mode <= c.mode;
      stack_fault_reset_enable <= c.en;
      {gie_h, gie_l} <= c.gie;
      interrupt_high_priority <= c.hp;
      saw_rst = 1'b0;
      saw_pcl = 1'b0;
      ev(c.kind);
      repeat (4) @(posedge hclk);
      wait_rel(0, 40);
      rd(REG_FLAGS_OFF, {24'h0, c.exp}, "flags event");
      chk("flags port", c.exp, flags);
      chk("reset seen", c.rst, saw_rst);
      chk("pc load seen", c.pc !== '1, saw_pcl);
      if (c.pc !== '1) chk("pc load", c.pc, pc_load_value);
    end
    power_mode <= PM_FULL;
    ahb(1'b1, REG_FLAGS_OFF, 32'h3f);
    config_shadow <= config_word;
    repeat (10) @(posedge hclk);
    chk("mismatch reset", 0, internal_reset_n);
    ahb(1'b0, REG_STATUS_OFF, 32'h0);
    chk("status mismatch", 1, rv[2]);
    rd(REG_FLAGS_OFF, 32'h1f, "flags mismatch");
    config_shadow <= ~config_word;
    wait_rel(0, 40);
    ev(3'h0);
    repeat (4) @(posedge hclk);
    wait_rel(0, 40);
    rd(REG_FLAGS_OFF, 32'h0f, "flags mismatch kept");
    ahb(1'b1, REG_FLAGS_OFF, 32'h03);
    regulator_enable <= 1'b0;
    supply_sag <= 1'b1;
    repeat (20) @(posedge hclk);
    chk("brownout inhibited", 1, internal_reset_n);
    supply_sag <= 1'b0;
    rd(REG_FLAGS_OFF, 32'h03, "flags inhibited");
    regulator_enable <= 1'b1;
    supply_sag <= 1'b1;
    repeat (30) @(posedge hclk);
    chk("brownout held", 0, internal_reset_n);
    rd(REG_FLAGS_OFF, 32'h3e, "flags brownout");
    supply_sag <= 1'b0;
    repeat (2000) @(posedge hclk);
    supply_sag <= 1'b1;
    repeat (10) @(posedge hclk);
    supply_sag <= 1'b0;
    wait_rel(2047 * 4, 2048 * 4 + 80);
    ahb(1'b1, REG_FLAGS_OFF, 32'h3f);
    regulator_enable <= 1'b0;
    pin_press <= 1'b1;
    supply_up <= 1'b0;
    repeat (10) @(posedge hclk);
    supply_up <= 1'b1;
    repeat (2048 * 4 + 200) @(posedge hclk);
    chk("pin holds reset", 0, internal_reset_n);
    rd(REG_FLAGS_OFF, 32'h3c, "flags power-on again");
    pin_press <= 1'b0;
    wait_rel(0, 8);
    end_of_test();
  end
endmodule : rcpt_reset_cause_tb
`default_nettype wire
